/* File: common/seep_pkg.sv */
package seep_pkg;

    // ========================================================================
    // Control byte layout
    localparam logic [3:0] DEV_CODE     = 4'ha;   // Device-type code 1010
    localparam int         CODE_MSB     = 7;
    localparam int         CODE_LSB     = 4;
    localparam int         BLK_MSB      = 3;
    localparam int         BLK_LSB      = 1;
    localparam int         RW_BIT       = 0;
    localparam int         BLK_W        = 3;

    // ========================================================================
    // Memory and page geometry
    localparam int         ADDR_W_DEF   = 10;     // Two block-select bits used
    localparam int         WORD_BITS    = 8;
    localparam int         PAGE_BITS    = 4;      // 16-byte page
    localparam int         PAGE_BYTES   = 16;
    localparam int         BUF_W        = PAGE_BITS + WORD_BITS;
    localparam int         BITS_PER_BYTE = 8;

    // ========================================================================
    // Timing
    localparam int         CLK_PERIOD_NS = 40;
    localparam int         PROG_TIME_MS  = 10;
    localparam int         PROG_CYC      = (PROG_TIME_MS * 1000000) / CLK_PERIOD_NS;

    // ========================================================================
    // Values after reset
    localparam logic [7:0] SHIFT_RST    = 8'h00;
    localparam logic [3:0] BITS_RST     = 4'h0;
    localparam logic [2:0] BLK_RST      = 3'h0;

    // ========================================================================
    // Bus-side states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_CTRL  = 3'b001,
        ST_ADDR  = 3'b010,
        ST_WDATA = 3'b011,
        ST_ACK   = 3'b100,
        ST_TX    = 3'b101,
        ST_MACK  = 3'b110
    } seep_state_t;

endpackage : seep_pkg

/* File: logic/seep_sync.sv */
`timescale 1ns/1ps
module seep_sync #(
    parameter int W = 4
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst,
    // Asynchronous inputs and filtered result
    input  wire logic [W-1:0] asyncIn,
    output logic      [W-1:0] filtOut
);

    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] filt_ff;
    logic [W-1:0] nxt_filt;

    // ========================================================================
    // Accept a change once second and third stages agree
    genvar gi;
    generate
        for (gi = 0; gi < W; gi++) begin : g_bit
            always_comb begin
                nxt_filt[gi] = (s2_ff[gi] == s3_ff[gi]) ? s3_ff[gi] : filt_ff[gi];
            end
        end
    endgenerate

    // Three-stage chain and filtered level
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s1_ff   <= '1;
            s2_ff   <= '1;
            s3_ff   <= '1;
            filt_ff <= '1;
        end else begin
            s1_ff   <= asyncIn;
            s2_ff   <= s1_ff;
            s3_ff   <= s2_ff;
            filt_ff <= nxt_filt;
        end
    end

    assign filtOut = filt_ff;

endmodule : seep_sync

/* File: logic/seep_fifo.sv */
`timescale 1ns/1ps
module seep_fifo #(
    parameter int W     = 12,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst,
    // Fill side
    input  wire logic         inValid,
    output logic              inReady,
    input  wire logic [W-1:0] inData,
    // Drain side
    output logic              outValid,
    input  wire logic         outReady,
    output logic      [W-1:0] outData
);

    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] store [DEPTH];
    logic [AW-1:0] wrPtr_ff;
    logic [AW-1:0] rdPtr_ff;
    logic [AW:0]   count_ff;
    logic [AW-1:0] nxt_wrPtr;
    logic [AW-1:0] nxt_rdPtr;
    logic [AW:0]   nxt_count;
    logic          doPush;
    logic          doPop;

    // ========================================================================
    // Handshake: a full buffer accepts only when a pop frees room
    always_comb begin
        outValid  = (count_ff != '0);
        inReady   = (count_ff != (AW+1)'(DEPTH)) || outReady;
        doPop     = outValid && outReady;
        doPush    = inValid && inReady;
        nxt_wrPtr = doPush ? AW'(wrPtr_ff + 1'b1) : wrPtr_ff;
        nxt_rdPtr = doPop ? AW'(rdPtr_ff + 1'b1) : rdPtr_ff;
        nxt_count = count_ff;
        if (doPush && !doPop) begin
            nxt_count = (AW+1)'(count_ff + 1'b1);
        end else if (doPop && !doPush) begin
            nxt_count = (AW+1)'(count_ff - 1'b1);
        end
        outData   = store[rdPtr_ff];
    end

    // Pointers and occupancy
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            count_ff <= '0;
        end else begin
            wrPtr_ff <= nxt_wrPtr;
            rdPtr_ff <= nxt_rdPtr;
            count_ff <= nxt_count;
        end
    end

    // Storage array
    always_ff @(posedge ref_clk) begin
        if (doPush) begin
            store[wrPtr_ff] <= inData;
        end
    end

endmodule : seep_fifo

/* File: logic/seep_slave.sv */
`timescale 1ns/1ps
module seep_slave #(
    parameter int          ADDR_W      = seep_pkg::ADDR_W_DEF,
    parameter int unsigned PROG_CYCLES = seep_pkg::PROG_CYC,
    parameter int          BUF_DEPTH   = seep_pkg::PAGE_BYTES
) (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // Two-wire bus
    input  wire logic       scl,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOeN,
    // Straps and supply monitor
    input  wire logic       writeProtect,
    input  wire logic       lowSupply,
    input  wire logic [2:0] unused_select_pins,
    // Status
    output logic            progBusy
);

    localparam int MEM_WORDS = 1 << ADDR_W;
    localparam int FULL_W    = seep_pkg::BLK_W + seep_pkg::WORD_BITS;

    // ========================================================================
    // Declarations
    logic [3:0]                 filt;
    logic                       sclS;
    logic                       sdaS;
    logic                       wpS;
    logic                       lowS;
    logic                       sclPrev_ff;
    logic                       sdaPrev_ff;
    logic                       sclRise;
    logic                       sclFall;
    logic                       startEv;
    logic                       stopEv;

    seep_pkg::seep_state_t      state_ff;
    seep_pkg::seep_state_t      nxt_state;
    seep_pkg::seep_state_t      after_ff;
    seep_pkg::seep_state_t      nxt_after;
    logic [3:0]                 bitCnt_ff;
    logic [3:0]                 nxt_bitCnt;
    logic [7:0]                 shift_ff;
    logic [7:0]                 nxt_shift;
    logic [ADDR_W-1:0]          ptr_ff;
    logic [ADDR_W-1:0]          nxt_ptr;
    logic [2:0]                 blk_ff;
    logic [2:0]                 nxt_blk;
    logic                       sdaOeN_ff;
    logic                       nxt_sdaOeN;
    logic                       sdaOut_ff;

    logic                       progBusy_ff;
    logic                       nxt_progBusy;
    logic                       flush_ff;
    logic                       nxt_flush;
    logic [31:0]                progCnt_ff;
    logic [31:0]                nxt_progCnt;

    logic                       pushValid;
    logic                       pushReady;
    logic [seep_pkg::BUF_W-1:0] pushData;
    logic                       popValid;
    logic                       popReady;
    logic [seep_pkg::BUF_W-1:0] popData;
    logic                       memWrEn;
    logic [ADDR_W-1:0]          memWrAddr;
    logic [FULL_W-1:0]          fullAddr;
    logic [7:0]                 mem [MEM_WORDS];

    // ========================================================================
    // Input synchronisers; select pins never enter the logic
    seep_sync #(
        .W       (4)
    ) u_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .asyncIn ({lowSupply, writeProtect, sdaIn, scl}),
        .filtOut (filt)
    );

    // Filtered levels
    assign sclS = filt[0];
    assign sdaS = filt[1];
    assign wpS  = filt[2];
    assign lowS = filt[3];

    // ========================================================================
    // Page buffer between bus and array
    seep_fifo #(
        .W        (seep_pkg::BUF_W),
        .DEPTH    (BUF_DEPTH)
    ) u_page (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .inValid  (pushValid),
        .inReady  (pushReady),
        .inData   (pushData),
        .outValid (popValid),
        .outReady (popReady),
        .outData  (popData)
    );

    // ========================================================================
    // Bus edge and condition detection
    always_comb begin
        sclRise = sclS && !sclPrev_ff;
        sclFall = !sclS && sclPrev_ff;
        startEv = sclS && sclPrev_ff && sdaPrev_ff && !sdaS;
        stopEv  = sclS && sclPrev_ff && !sdaPrev_ff && sdaS;
    end

    // Previous filtered levels
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sclPrev_ff <= 1'b1;
            sdaPrev_ff <= 1'b1;
        end else begin
            sclPrev_ff <= sclS;
            sdaPrev_ff <= sdaS;
        end
    end

    // ========================================================================
    // Bus protocol engine
    always_comb begin
        nxt_state  = state_ff;
        nxt_after  = after_ff;
        nxt_bitCnt = bitCnt_ff;
        nxt_shift  = shift_ff;
        nxt_ptr    = ptr_ff;
        nxt_blk    = blk_ff;
        nxt_sdaOeN = sdaOeN_ff;
        pushValid  = 1'b0;
        pushData   = {ptr_ff[seep_pkg::PAGE_BITS-1:0], shift_ff};
        fullAddr   = {blk_ff, shift_ff};
        if (startEv) begin
            // Start or repeated start: expect a control byte
            nxt_state  = seep_pkg::ST_CTRL;
            nxt_bitCnt = seep_pkg::BITS_RST;
            nxt_sdaOeN = 1'b1;
        end else if (stopEv) begin
            nxt_state  = seep_pkg::ST_IDLE;
            nxt_sdaOeN = 1'b1;
        end else begin
            unique case (state_ff)
                seep_pkg::ST_IDLE: begin
                    nxt_sdaOeN = 1'b1;
                end
                seep_pkg::ST_CTRL, seep_pkg::ST_ADDR, seep_pkg::ST_WDATA: begin
                    if (sclRise && bitCnt_ff != 4'(seep_pkg::BITS_PER_BYTE)) begin
                        nxt_shift  = {shift_ff[6:0], sdaS};
                        nxt_bitCnt = 4'(bitCnt_ff + 1'b1);
                    end else if (sclFall && bitCnt_ff == 4'(seep_pkg::BITS_PER_BYTE)) begin
                        nxt_bitCnt = seep_pkg::BITS_RST;
                        nxt_state  = seep_pkg::ST_ACK;
                        nxt_sdaOeN = 1'b0;                     // Pull low for ack
                        if (state_ff == seep_pkg::ST_CTRL) begin
                            if (shift_ff[seep_pkg::CODE_MSB:seep_pkg::CODE_LSB]
                                    != seep_pkg::DEV_CODE || progBusy_ff) begin
                                nxt_state  = seep_pkg::ST_IDLE;
                                nxt_sdaOeN = 1'b1;
                            end else begin
                                nxt_blk   = shift_ff[seep_pkg::BLK_MSB:seep_pkg::BLK_LSB];
                                nxt_after = shift_ff[seep_pkg::RW_BIT]
                                          ? seep_pkg::ST_TX : seep_pkg::ST_ADDR;
                            end
                        end else if (state_ff == seep_pkg::ST_ADDR) begin
                            nxt_ptr   = fullAddr[ADDR_W-1:0];
                            nxt_after = seep_pkg::ST_WDATA;
                        end else begin
                            // Data byte into the page buffer
                            pushValid = 1'b1;
                            nxt_ptr   = {ptr_ff[ADDR_W-1:seep_pkg::PAGE_BITS],
                                         ptr_ff[seep_pkg::PAGE_BITS-1:0] + 4'h1};
                            nxt_after = seep_pkg::ST_WDATA;
                        end
                    end
                end
                seep_pkg::ST_ACK: begin
                    if (sclFall) begin
                        if (after_ff == seep_pkg::ST_TX) begin
                            // Load word at pointer, drive its MSB
                            nxt_shift  = mem[ptr_ff];
                            nxt_ptr    = ptr_ff + 1'b1;
                            nxt_sdaOeN = mem[ptr_ff][7];
                            nxt_bitCnt = 4'h1;
                            nxt_state  = seep_pkg::ST_TX;
                        end else begin
                            nxt_sdaOeN = 1'b1;
                            nxt_bitCnt = seep_pkg::BITS_RST;
                            nxt_state  = after_ff;
                        end
                    end
                end
                seep_pkg::ST_TX: begin
                    if (sclFall) begin
                        if (bitCnt_ff == 4'(seep_pkg::BITS_PER_BYTE)) begin
                            nxt_sdaOeN = 1'b1;                 // Free line for master ack
                            nxt_bitCnt = seep_pkg::BITS_RST;
                            nxt_state  = seep_pkg::ST_MACK;
                        end else begin
                            nxt_shift  = {shift_ff[6:0], 1'b0};
                            nxt_sdaOeN = shift_ff[6];          // MSB first
                            nxt_bitCnt = 4'(bitCnt_ff + 1'b1);
                        end
                    end
                end
                seep_pkg::ST_MACK: begin
                    if (sclRise) begin
                        if (!sdaS) begin
                            nxt_after = seep_pkg::ST_TX;       // Next word
                            nxt_state = seep_pkg::ST_ACK;
                        end else begin
                            nxt_state = seep_pkg::ST_IDLE;     // No ack: release
                        end
                    end
                end
                default: begin
                    nxt_state  = seep_pkg::ST_IDLE;
                    nxt_sdaOeN = 1'b1;
                end
            endcase
        end
    end

    // Protocol registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_ff  <= seep_pkg::ST_IDLE;
            after_ff  <= seep_pkg::ST_IDLE;
            bitCnt_ff <= seep_pkg::BITS_RST;
            shift_ff  <= seep_pkg::SHIFT_RST;
            ptr_ff    <= '0;
            blk_ff    <= seep_pkg::BLK_RST;
            sdaOeN_ff <= 1'b1;
            sdaOut_ff <= 1'b0;
        end else begin
            state_ff  <= nxt_state;
            after_ff  <= nxt_after;
            bitCnt_ff <= nxt_bitCnt;
            shift_ff  <= nxt_shift;
            ptr_ff    <= nxt_ptr;
            blk_ff    <= nxt_blk;
            sdaOeN_ff <= nxt_sdaOeN;
            sdaOut_ff <= 1'b0;                                 // Only ever low
        end
    end

    // ========================================================================
    // Programming cycle control
    always_comb begin
        nxt_progBusy = progBusy_ff;
        nxt_progCnt  = progCnt_ff;
        nxt_flush    = flush_ff && popValid;
        if (progBusy_ff) begin
            nxt_progCnt = progCnt_ff + 32'h0000_0001;
            if (progCnt_ff == PROG_CYCLES - 1) begin
                nxt_progBusy = 1'b0;
            end
        end else if (stopEv && popValid && !flush_ff) begin
            if (wpS || lowS) begin
                nxt_flush = 1'b1;                              // Discard buffer
            end else begin
                nxt_progBusy = 1'b1;                           // Self-timed start
                nxt_progCnt  = 32'h0000_0000;
            end
        end else if (startEv && popValid) begin
            nxt_flush = 1'b1;                                  // Write aborted by restart
        end
    end

    // Programming registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            progBusy_ff <= 1'b0;
            flush_ff    <= 1'b0;
            progCnt_ff  <= 32'h0000_0000;
        end else begin
            progBusy_ff <= nxt_progBusy;
            flush_ff    <= nxt_flush;
            progCnt_ff  <= nxt_progCnt;
        end
    end

    // ========================================================================
    // Buffer drain and array write; overflow drops oldest entry
    // Full buffer: head slot equals the slot being filled, no loop through ready
    always_comb begin
        popReady  = progBusy_ff || flush_ff
                 || (pushValid && popValid
                     && popData[seep_pkg::BUF_W-1:seep_pkg::WORD_BITS]
                        == ptr_ff[seep_pkg::PAGE_BITS-1:0]);
        memWrEn   = progBusy_ff && popValid && !wpS && !lowS;
        memWrAddr = {ptr_ff[ADDR_W-1:seep_pkg::PAGE_BITS],
                     popData[seep_pkg::BUF_W-1:seep_pkg::WORD_BITS]};
    end

    // Memory array
    always_ff @(posedge ref_clk) begin
        if (memWrEn) begin
            mem[memWrAddr] <= popData[seep_pkg::WORD_BITS-1:0];
        end
    end

    // ========================================================================
    // Outputs
    assign sdaOut   = sdaOut_ff;
    assign sdaOeN   = sdaOeN_ff;
    assign progBusy = progBusy_ff;

endmodule : seep_slave

/* File: verif/seep_chk.sv */
`timescale 1ns/1ps
module seep_chk #(
    parameter int unsigned PROG_CYCLES = 200
) (
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       rst,
    // Bus, straps and status
    input wire logic       scl,
    input wire logic       sdaIn,
    input wire logic       sdaOut,
    input wire logic       sdaOeN,
    input wire logic       writeProtect,
    input wire logic       lowSupply,
    input wire logic [2:0] unused_select_pins,
    input wire logic       progBusy
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ========================================
    // Helper counters
    logic [31:0] busyCnt_ff, nxt_busyCnt;
    logic [3:0]  stopAge_ff, nxt_stopAge;
    logic        sdaPrev_ff, stopDet;
    // Stop on the pins, busy length, age of last stop
    always_comb begin
        stopDet     = sdaIn && !sdaPrev_ff && scl;
        nxt_busyCnt = progBusy ? busyCnt_ff + 32'h1 : 32'h0;
        nxt_stopAge = stopDet ? 4'h0 : stopAge_ff + {3'h0, stopAge_ff != 4'hf};
    end
    // Register only
    always_ff @(posedge ref_clk) begin
        busyCnt_ff <= rst ? 32'h0 : nxt_busyCnt;
        stopAge_ff <= rst ? 4'hf : nxt_stopAge;
        sdaPrev_ff <= sdaIn;
    end
    // ========================================
    // Assertions
    a_busy_quiet: assert property (progBusy |-> sdaOeN)
        else $error("device drove data line while programming");
    a_busy_length: assert property ($fell(progBusy) |-> busyCnt_ff == PROG_CYCLES)
        else $error("programming cycle length wrong");
    a_busy_after_stop: assert property ($rose(progBusy) |-> stopAge_ff <= 4'hc)
        else $error("programming began without a recent stop");
    a_busy_permit: assert property ($rose(progBusy) |-> !writeProtect && !lowSupply)
        else $error("programming began while inhibited");
    a_drive_only_low: assert property (sdaOut == 1'b0)
        else $error("data pin driven high");
    a_change_scl_low: assert property ($changed(sdaOeN) |-> !scl)
        else $error("data line changed while clock high");
    a_stop_release: assert property (stopDet |-> sdaOeN [*8])
        else $error("data line not released after stop");
    a_reset_idle: assert property (disable iff (1'b0) rst |=> sdaOeN && !progBusy)
        else $error("outputs not idle after reset");
    // Main scenarios
    c_prog: cover property ($fell(progBusy));
    c_drive: cover property ($fell(sdaOeN));
    c_stop: cover property (stopDet);
endmodule : seep_chk

bind seep_slave seep_chk #(.PROG_CYCLES(PROG_CYCLES)) u_chk (.ref_clk(ref_clk), .rst(rst),
    .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .writeProtect(writeProtect),
    .lowSupply(lowSupply), .unused_select_pins(unused_select_pins), .progBusy(progBusy));

/* File: verif/seep_master.sv */
`timescale 1ns/1ps
module seep_master (
    // Clock
    input wire logic ref_clk,
    // Bus, release is 1
    output logic     scl,
    output logic     sdaDrv,
    input wire logic sdaWire
);
    initial begin
        scl    = 1'b1;
        sdaDrv = 1'b1;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : cyc
    // One bit, 320 ns: data set only in the low phase
    task automatic bitX(input logic b, output logic r);
        cyc(1);
        sdaDrv <= b;
        cyc(5);
        scl <= 1'b1;
        cyc(1);
        r = sdaWire;
        cyc(1);
        scl <= 1'b0;
    endtask : bitX
    // Start or repeated start
    // Clock stays low long enough for the device to drop an acknowledge
    task automatic start();
        cyc(1);
        sdaDrv <= 1'b1;
        cyc(5);
        scl <= 1'b1;
        cyc(2);
        sdaDrv <= 1'b0;
        cyc(2);
        scl <= 1'b0;
    endtask : start
    // Stop, clock then stands high
    // Clock stays low long enough for the device to drop an acknowledge
    task automatic stop();
        cyc(1);
        sdaDrv <= 1'b0;
        cyc(5);
        scl <= 1'b1;
        cyc(2);
        sdaDrv <= 1'b1;
        cyc(4);
    endtask : stop
    // Byte out MSB first, then release the line and read the acknowledge bit
    task automatic wrByte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitX(d[i], r);
        bitX(1'b1, r);
        ack = ~r;
    endtask : wrByte
    // Byte in, then ack or nack
    task automatic rdByte(input logic ackIt, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bitX(1'b1, d[i]);
        bitX(~ackIt, r);
    endtask : rdByte
endmodule : seep_master

/* File: verif/tb.sv */
`timescale 1ns/1ps
module tb;
    localparam int unsigned PROG = 200;
    logic       ref_clk      = 1'b0;
    logic       rst          = 1'b1;
    logic       writeProtect = 1'b0;
    logic       lowSupply    = 1'b0;
    logic [2:0] selPins      = 3'h0;
    logic       scl, sdaDrv, sdaOut, sdaOeN, progBusy, ack;
    wire        sdaWire = sdaOeN ? sdaDrv : 1'b0;
    logic [7:0] mem [1024];
    logic [9:0] ptr, a;
    int         failures = 0;
    int         checked  = 0;
    int         seed     = 32'ha94a_2616;
    // Clock
    always #20 ref_clk = ~ref_clk;
    seep_slave #(.PROG_CYCLES(PROG)) dut (.ref_clk(ref_clk), .rst(rst), .scl(scl),
        .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .writeProtect(writeProtect),
        .lowSupply(lowSupply), .unused_select_pins(selPins), .progBusy(progBusy));
    seep_master bus (.ref_clk(ref_clk), .scl(scl), .sdaDrv(sdaDrv), .sdaWire(sdaWire));
    // ========================================
    // Checks and verdict
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic summarize();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize
    function automatic logic [9:0] inPage(input logic [9:0] b, input int i);
        return {b[9:4], b[3:0] + i[3:0]};
    endfunction : inPage
    // ========================================
    // Transactions
    task automatic setAddr(input logic [9:0] x);
        bus.start();
        bus.wrByte({4'ha, 1'b0, x[9:8], 1'b0}, ack);
        chk("ctrl ack", 8'h1, {7'h0, ack});
        bus.wrByte(x[7:0], ack);
        ptr = x;
    endtask : setAddr
    task automatic poll();
        ack = 1'b0;
        for (int k = 0; k < 30 && ack !== 1'b1; k++) begin
            bus.start();
            bus.wrByte(8'ha0, ack);
            if (k == 0) chk("busy nack", 8'h0, {7'h0, ack});
        end
        bus.stop();
        if (ack !== 1'b1) begin
            chk("poll ack", 8'h1, {7'h0, ack});
            summarize();
        end
    endtask : poll
    task automatic wrPage(input logic [9:0] x, input int n, input logic prog);
        logic [7:0] d;
        setAddr(x);
        for (int i = 0; i < n; i++) begin
            d = 8'($random(seed));
            bus.wrByte(d, ack);
            chk("data ack", 8'h1, {7'h0, ack});
            if (prog) mem[inPage(x, i)] = d;
        end
        bus.stop();
        ptr = inPage(x, n);
        bus.cyc(10);
        chk("busy", {7'h0, prog}, {7'h0, progBusy});
        if (prog) poll();
    endtask : wrPage
    task automatic rdSeq(input int n);
        logic [7:0] d;
        bus.start();
        bus.wrByte(8'ha1, ack);
        chk("rd ack", 8'h1, {7'h0, ack});
        for (int i = 0; i < n; i++) begin
            bus.rdByte(i < n - 1, d);
            chk("rd data", mem[ptr], d);
            ptr = ptr + 10'h1;
        end
        bus.stop();
        chk("released", 8'h1, {7'h0, sdaOeN});
    endtask : rdSeq
    // ========================================
    // Main sequence
    initial begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        bus.cyc(10);
        wrPage(10'h3f0, 16, 1'b1);
        wrPage(10'h000, 16, 1'b1);
        setAddr(10'h3f8);
        rdSeq(16);
        for (int k = 0; k < 6; k++) begin
            a = 10'($random(seed));
            selPins <= 3'($random(seed));
            wrPage(a, 16 + k % 3, 1'b1);
            rdSeq(1);
            setAddr({a[9:4], 4'h0});
            rdSeq(16);
        end
        for (int k = 0; k < 2; k++) begin
            writeProtect <= (k == 0);
            lowSupply <= (k == 1);
            wrPage(10'h000, 16, 1'b0);
            setAddr(10'h000);
            rdSeq(16);
        end
        writeProtect <= 1'b0;
        lowSupply <= 1'b0;
        foreach (a[i]) begin
            bus.start();
            bus.wrByte({4'ha ^ 4'(i + 1), 4'(i)}, ack);
            chk("bad code ack", 8'h0, {7'h0, ack});
            bus.stop();
        end
        summarize();
    end
endmodule : tb
